// ==== rpd_core_model.sv ====
/*
 * Core model: turns a requested instruction code into its exec strobe.
 * Assumes the bench changes the code at falling edges, one cycle each.
 */
`timescale 1ns/1ps
`default_nettype none

module rpd_core_model (
	// instruction request, 0 means none
	input wire logic [2:0] op_code,
	// strobes to the sequencer
	output logic exec_arm_power_down,
	output logic exec_enter_clock_run_sleep,
	output logic exec_enter_ram_retention,
	output logic exec_latch_dropout_detect_enable
);
	// one strobe per executed instruction
	assign exec_arm_power_down = (op_code == 3'h1);
	assign exec_enter_clock_run_sleep = (op_code == 3'h2);
	assign exec_enter_ram_retention = (op_code == 3'h3);
	assign exec_latch_dropout_detect_enable = (op_code == 3'h4);
endmodule

`default_nettype wire

// ==== rpd_ctl_if.sv ====
/*
 * Carrier between the reset sequencer and the power-down controller.
 * Assumes both ends run on core_clk; every signal is same-clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface rpd_ctl_if;
	import rpd_pkg::*;
	logic sys_reset; // system reset level
	logic arm; // arm instruction strobe
	logic enter_clk; // first power-off strobe
	logic enter_ram; // second power-off strobe
	logic wake_ext; // filtered external wakeup level
	logic t3_flag; // slow timer expiry level
	rpd_mode_t mode; // current mode
	logic warm_pulse; // one-cycle warm start
	logic p_flag; // power-down flag
	logic armed; // arm state

	// power-down controller end
	modport pd (
		input sys_reset, arm, enter_clk, enter_ram, wake_ext, t3_flag,
		output mode, warm_pulse, p_flag, armed
	);
	// sequencer end
	modport seq (
		output sys_reset, arm, enter_clk, enter_ram, wake_ext, t3_flag,
		input mode, warm_pulse, p_flag, armed
	);
endinterface

`default_nettype wire

// ==== rpd_defs.svh ====
/*
 * Constants for the reset and power-down sequencer: timing counts,
 * restart vector and the values forced while the system sits in reset.
 * Assumes it is included by bare name from every design file that needs it.
 */
// How it works
// - reset pin low one cycle resets system; the code resets only on a low sampled at two consecutive core_clk edges
// - reset release restarts fetch at zero
// - port output latches forced high in reset
// - ports open-drain, segment pull-ups off in reset
// - reset defines only a fixed subset state
// - power-on reset happens without pin pulse
// - supply dropout below threshold causes reset
// - latched detector stays active in power-down
// - detector enable latch sets only once
// - only system reset clears detector latch
// - arm then first off enters clock-run
// - arm then second off enters retention
// - unarmed power-off instruction acts as no-op
// - each mode keeps only its listed functions
// - wakeup or timer expiry warm-starts, flag one
// - pin, watchdog or dropout cold-start, flag zero
// - retention wakes only on external wakeup
`ifndef RPD_DEFS_SVH
`define RPD_DEFS_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RPD_CLK_PERIOD_NS 40
`define RPD_POR_TIME_NS 100000
`define RPD_POR_CYCLES ((`RPD_POR_TIME_NS + `RPD_CLK_PERIOD_NS - 1) / `RPD_CLK_PERIOD_NS)
`define RPD_RST_HOLD_CYCLES 4
`define RPD_RESTART_WIDTH 8

// ---------------------------------------------------------------
// restart vector and flag values
// ---------------------------------------------------------------
`define RPD_RESTART_PAGE 8'h00
`define RPD_RESTART_ADDR 8'h00
`define RPD_PFLAG_WARM 1'b1
`define RPD_PFLAG_COLD 1'b0

// ---------------------------------------------------------------
// pin state forced during reset
// ---------------------------------------------------------------
`define RPD_PORT_LATCH_RST 1'b1
`define RPD_OPEN_DRAIN_RST 1'b1
`define RPD_PULLUP_OFF_RST 1'b1

`endif

// ==== rpd_pkg.sv ====
/*
 * Types shared by the sequencer modules: operating modes and reset states.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package rpd_pkg;
	// operating mode of the core
	typedef enum logic [1:0] {
		RPD_MODE_RUN = 2'b00,
		RPD_MODE_CLK_SLEEP = 2'b01,
		RPD_MODE_RAM_RET = 2'b10
	} rpd_mode_t;

	// system reset sequencer states
	typedef enum logic [1:0] {
		RPD_RS_POWER_ON = 2'b00,
		RPD_RS_HOLD = 2'b01,
		RPD_RS_RUN = 2'b10
	} rpd_rst_state_t;
endpackage

`default_nettype wire

// ==== rpd_pwrdn.sv ====
/*
 * Power-down controller: arm state, mode entry and warm-start wakeup.
 * Assumes strobes arrive only while the core runs and are one cycle long.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rpd_defs.svh"

module rpd_pwrdn
	import rpd_pkg::*;
(
	// clock
	input wire logic core_clk,
	// sequencer link
	rpd_ctl_if.pd ctl
);
	logic armed_ff; // arm state
	rpd_mode_t mode_ff; // current mode
	logic warm_ff; // warm start pulse
	logic p_ff; // power-down flag
	logic consume; // armed power-off instruction
	logic go_clk; // enter clock-run sleep
	logic go_ram; // enter ram retention
	logic wake_clk; // wakeup out of clock-run
	logic wake_ram; // wakeup out of retention
	logic wake; // any wakeup

	assign consume = armed_ff && (ctl.enter_clk || ctl.enter_ram);
	assign go_clk = (mode_ff == RPD_MODE_RUN) && armed_ff && ctl.enter_clk;
	assign go_ram = (mode_ff == RPD_MODE_RUN) && armed_ff && ctl.enter_ram && !ctl.enter_clk;
	assign wake_clk = (mode_ff == RPD_MODE_CLK_SLEEP) && (ctl.wake_ext || ctl.t3_flag);
	assign wake_ram = (mode_ff == RPD_MODE_RAM_RET) && ctl.wake_ext;
	assign wake = wake_clk || wake_ram;

	// arm state: set by arm, cleared when consumed or by reset
	always_ff @(posedge core_clk) begin
		if (ctl.sys_reset) begin
			armed_ff <= 1'b0;
		end else if (consume) begin
			armed_ff <= 1'b0;
		end else if (ctl.arm) begin
			armed_ff <= 1'b1;
		end
	end

	// mode machine
	always_ff @(posedge core_clk) begin
		if (ctl.sys_reset) begin
			mode_ff <= RPD_MODE_RUN;
		end else begin
			case (mode_ff)
				RPD_MODE_RUN: begin
					if (go_clk) begin
						mode_ff <= RPD_MODE_CLK_SLEEP;
					end else if (go_ram) begin
						mode_ff <= RPD_MODE_RAM_RET;
					end
				end
				RPD_MODE_CLK_SLEEP: begin
					if (wake_clk) begin
						mode_ff <= RPD_MODE_RUN;
					end
				end
				RPD_MODE_RAM_RET: begin
					if (wake_ram) begin
						mode_ff <= RPD_MODE_RUN;
					end
				end
				default: begin
					mode_ff <= RPD_MODE_RUN;
				end
			endcase
		end
	end

	// warm pulse and power-down flag
	always_ff @(posedge core_clk) begin
		if (ctl.sys_reset) begin
			warm_ff <= 1'b0;
			p_ff <= `RPD_PFLAG_COLD;
		end else begin
			warm_ff <= wake;
			if (wake) begin
				p_ff <= `RPD_PFLAG_WARM;
			end
		end
	end

	assign ctl.mode = mode_ff;
	assign ctl.warm_pulse = warm_ff;
	assign ctl.p_flag = p_ff;
	assign ctl.armed = armed_ff;
endmodule

`default_nettype wire

// ==== rpd_seq.sv ====
/*
 * Reset and power-down sequencer top: qualifies reset sources, runs the
 * power-on stretch, latches the dropout detector enable, and drives the
 * restart vector, pin-state forcing and per-mode function enables.
 * Assumes core_clk keeps running for this block in every mode, the
 * instruction strobes come from the core on the same clock, and rst
 * marks the application of power.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rpd_defs.svh"

module rpd_seq
	import rpd_pkg::*;
#(
	parameter int POR_CYCLES = `RPD_POR_CYCLES,
	parameter int HOLD_CYCLES = `RPD_RST_HOLD_CYCLES
) (
	// clock and power-on reset
	input wire logic core_clk,
	input wire logic rst,
	// pins, asynchronous
	input wire logic reset_pin_n,
	input wire logic dropout_threshold,
	input wire logic wakeup_ext,
	// same-clock reset and wakeup sources
	input wire logic watchdog_reset,
	input wire logic slow_timer_expiry_flag,
	// instruction strobes from the core
	input wire logic exec_arm_power_down,
	input wire logic exec_enter_clock_run_sleep,
	input wire logic exec_enter_ram_retention,
	input wire logic exec_latch_dropout_detect_enable,
	// reset and restart
	output logic sys_reset_ff,
	output logic restart_strobe_ff,
	output logic [`RPD_RESTART_WIDTH-1:0] restart_page_ff,
	output logic [`RPD_RESTART_WIDTH-1:0] restart_addr_ff,
	output logic power_down_flag_ff,
	output logic cpu_run_ff,
	output logic [1:0] mode_ff,
	output logic armed_ff,
	// pin state forcing
	output logic port_latch_force_one_ff,
	output logic port_open_drain_ff,
	output logic seg_pullup_off_ff,
	// function enables
	output logic main_osc_en_ff,
	output logic sub_osc_en_ff,
	output logic lcd_en_ff,
	output logic slow_timer_en_ff,
	output logic ram_retain_ff,
	output logic dropout_detect_active_ff,
	output logic dropout_latched_ff
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	localparam int CW = $clog2(POR_CYCLES + HOLD_CYCLES + 1);

	rpd_ctl_if ctl (); // link to the power-down controller

	logic pin_level; // qualified reset pin level
	logic drop_level; // qualified dropout comparator level
	logic wake_level; // qualified wakeup level
	rpd_rst_state_t rs_ff; // reset sequencer state
	rpd_rst_state_t nxt_rs; // next sequencer state
	logic [CW-1:0] cnt_ff; // stretch counter
	logic [CW-1:0] nxt_cnt; // next counter value
	logic dl_ff; // dropout detect enable latch
	logic in_reset; // system reset level, internal
	logic running; // core executing in run mode
	logic detect_on; // detector able to reset
	logic pin_req; // reset from pin
	logic drop_req; // reset from dropout
	logic reset_req; // any cold reset source
	logic por_done; // power-on stretch complete
	logic hold_done; // hold stretch complete
	logic cold_release; // leaving reset this cycle
	logic nxt_strobe; // restart strobe next
	logic nxt_main; // main oscillator enable next
	logic nxt_sub; // sub oscillator enable next
	logic nxt_lcd; // lcd enable next
	logic nxt_t3; // slow timer enable next

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// reset pin idles high
	rpd_sync3 #(.RST_VAL(1'b1)) u_sync_pin (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(reset_pin_n),
		.level_ff(pin_level)
	);

	// dropout comparator, high while supply is low
	rpd_sync3 #(.RST_VAL(1'b0)) u_sync_drop (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(dropout_threshold),
		.level_ff(drop_level)
	);

	// external wakeup, high requests return
	rpd_sync3 #(.RST_VAL(1'b0)) u_sync_wake (
		.core_clk(core_clk),
		.rst(rst),
		.async_in(wakeup_ext),
		.level_ff(wake_level)
	);

	// ---------------------------------------------------------------
	// reset source decode
	// ---------------------------------------------------------------
	assign in_reset = (rs_ff != RPD_RS_RUN);
	assign running = !in_reset && (ctl.mode == RPD_MODE_RUN);
	// unlatched detector only watches while the core runs
	assign detect_on = running || dl_ff;
	// a low seen by two agreeing stages lasted a full cycle
	assign pin_req = !pin_level;
	assign drop_req = drop_level && detect_on;
	assign reset_req = pin_req || watchdog_reset || drop_req;
	assign por_done = (cnt_ff == CW'(POR_CYCLES - 1));
	assign hold_done = (cnt_ff == CW'(HOLD_CYCLES - 1));
	assign cold_release = (nxt_rs == RPD_RS_RUN) && in_reset;

	// ---------------------------------------------------------------
	// reset sequencer next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_rs = rs_ff;
		nxt_cnt = cnt_ff;
		case (rs_ff)
			RPD_RS_POWER_ON: begin
				// stretch after power is applied, no pin pulse needed
				if (reset_req) begin
					nxt_rs = RPD_RS_HOLD;
					nxt_cnt = '0;
				end else if (por_done) begin
					nxt_rs = RPD_RS_RUN;
					nxt_cnt = '0;
				end else begin
					nxt_cnt = cnt_ff + CW'(1);
				end
			end
			RPD_RS_HOLD: begin
				// restart the hold while the pin or watchdog request persists
				if (reset_req) begin
					nxt_cnt = '0;
				end else if (hold_done) begin
					nxt_rs = RPD_RS_RUN;
					nxt_cnt = '0;
				end else begin
					nxt_cnt = cnt_ff + CW'(1);
				end
			end
			RPD_RS_RUN: begin
				if (reset_req) begin
					nxt_rs = RPD_RS_HOLD;
					nxt_cnt = '0;
				end
			end
			default: begin
				nxt_rs = RPD_RS_POWER_ON;
				nxt_cnt = '0;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rs_ff <= RPD_RS_POWER_ON;
			cnt_ff <= '0;
		end else begin
			rs_ff <= nxt_rs;
			cnt_ff <= nxt_cnt;
		end
	end

	// ---------------------------------------------------------------
	// dropout detect enable latch
	// ---------------------------------------------------------------
	// set once by the instruction; nothing but reset clears it
	always_ff @(posedge core_clk) begin
		if (rst || in_reset) begin
			dl_ff <= 1'b0;
		end else if (running && exec_latch_dropout_detect_enable) begin
			dl_ff <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// power-down controller link
	// ---------------------------------------------------------------
	// strobes only count while the core executes
	assign ctl.sys_reset = rst || in_reset;
	assign ctl.arm = running && exec_arm_power_down;
	assign ctl.enter_clk = running && exec_enter_clock_run_sleep;
	assign ctl.enter_ram = running && exec_enter_ram_retention;
	assign ctl.wake_ext = wake_level;
	assign ctl.t3_flag = slow_timer_expiry_flag;

	rpd_pwrdn u_pwrdn (
		.core_clk(core_clk),
		.ctl(ctl.pd)
	);

	// ---------------------------------------------------------------
	// function enables per mode
	// ---------------------------------------------------------------
	// main clock stops in both power-down modes
	assign nxt_main = in_reset || (ctl.mode == RPD_MODE_RUN);
	// sub clock, lcd and slow timer keep going in clock-run sleep
	assign nxt_sub = in_reset || (ctl.mode != RPD_MODE_RAM_RET);
	assign nxt_lcd = !in_reset && (ctl.mode != RPD_MODE_RAM_RET);
	assign nxt_t3 = !in_reset && (ctl.mode != RPD_MODE_RAM_RET);
	// restart on cold release or warm wakeup
	assign nxt_strobe = cold_release || ctl.warm_pulse;

	// ---------------------------------------------------------------
	// output registers
	// ---------------------------------------------------------------
	// reset level, pin forcing and restart vector
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sys_reset_ff <= 1'b1;
			port_latch_force_one_ff <= `RPD_PORT_LATCH_RST;
			port_open_drain_ff <= `RPD_OPEN_DRAIN_RST;
			seg_pullup_off_ff <= `RPD_PULLUP_OFF_RST;
			restart_strobe_ff <= 1'b0;
			restart_page_ff <= `RPD_RESTART_PAGE;
			restart_addr_ff <= `RPD_RESTART_ADDR;
		end else begin
			sys_reset_ff <= (nxt_rs != RPD_RS_RUN);
			// pins forced only while reset stands
			port_latch_force_one_ff <= (nxt_rs != RPD_RS_RUN);
			port_open_drain_ff <= (nxt_rs != RPD_RS_RUN);
			seg_pullup_off_ff <= (nxt_rs != RPD_RS_RUN);
			restart_strobe_ff <= nxt_strobe;
			restart_page_ff <= `RPD_RESTART_PAGE;
			restart_addr_ff <= `RPD_RESTART_ADDR;
		end
	end

	// state shown to the core and clock tree
	always_ff @(posedge core_clk) begin
		if (rst) begin
			// only this subset is defined by reset
			power_down_flag_ff <= `RPD_PFLAG_COLD;
			cpu_run_ff <= 1'b0;
			mode_ff <= RPD_MODE_RUN;
			armed_ff <= 1'b0;
		end else begin
			power_down_flag_ff <= ctl.p_flag;
			cpu_run_ff <= running;
			mode_ff <= ctl.mode;
			armed_ff <= ctl.armed;
		end
	end

	// function enables
	always_ff @(posedge core_clk) begin
		if (rst) begin
			main_osc_en_ff <= 1'b1;
			sub_osc_en_ff <= 1'b1;
			lcd_en_ff <= 1'b0;
			slow_timer_en_ff <= 1'b0;
			ram_retain_ff <= 1'b1;
			dropout_detect_active_ff <= 1'b0;
			dropout_latched_ff <= 1'b0;
		end else begin
			main_osc_en_ff <= nxt_main;
			sub_osc_en_ff <= nxt_sub;
			lcd_en_ff <= nxt_lcd;
			slow_timer_en_ff <= nxt_t3;
			// ram always kept, every mode
			ram_retain_ff <= 1'b1;
			dropout_detect_active_ff <= detect_on;
			dropout_latched_ff <= dl_ff;
		end
	end
endmodule

`default_nettype wire

// ==== rpd_seq_monitor.sv ====
/*
 * Checker for the reset and power-down sequencer: assertions on top ports.
 * Assumes it is bound to rpd_seq, every input named as the port it watches.
 */
`timescale 1ns/1ps
`default_nettype none

module rpd_seq_monitor (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// sources
	input wire logic reset_pin_n,
	input wire logic dropout_threshold,
	input wire logic wakeup_ext,
	input wire logic watchdog_reset,
	input wire logic slow_timer_expiry_flag,
	// instruction strobes
	input wire logic exec_arm_power_down,
	input wire logic exec_enter_clock_run_sleep,
	input wire logic exec_enter_ram_retention,
	input wire logic exec_latch_dropout_detect_enable,
	// sequencer outputs
	input wire logic sys_reset_ff,
	input wire logic restart_strobe_ff,
	input wire logic [7:0] restart_page_ff,
	input wire logic [7:0] restart_addr_ff,
	input wire logic power_down_flag_ff,
	input wire logic cpu_run_ff,
	input wire logic [1:0] mode_ff,
	input wire logic armed_ff,
	input wire logic port_latch_force_one_ff,
	input wire logic port_open_drain_ff,
	input wire logic seg_pullup_off_ff,
	input wire logic main_osc_en_ff,
	input wire logic sub_osc_en_ff,
	input wire logic lcd_en_ff,
	input wire logic slow_timer_en_ff,
	input wire logic ram_retain_ff,
	input wire logic dropout_latched_ff
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// -------------------------------------------------------------
	// helper: cycles the wakeup pin has been quiet, saturating
	// -------------------------------------------------------------
	logic [2:0] wake_quiet_ff;
	always_ff @(posedge core_clk) begin
		if (rst || wakeup_ext) begin
			wake_quiet_ff <= 3'h0;
		end else if (wake_quiet_ff != 3'h7) begin
			wake_quiet_ff <= wake_quiet_ff + 3'h1;
		end
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	a_pin_reset: assert property ($fell(reset_pin_n) ##1 (!reset_pin_n)[*4] |-> ##[0:3] sys_reset_ff)
		else $error("pin held low gave no reset");
	a_dog_reset: assert property (watchdog_reset |=> sys_reset_ff)
		else $error("watchdog request gave no reset");
	a_drop_reset: assert property ($rose(dropout_threshold) && dropout_latched_ff |-> ##[1:8] sys_reset_ff)
		else $error("latched dropout gave no reset");
	a_restart_vec: assert property ($fell(sys_reset_ff) |-> restart_strobe_ff && restart_page_ff == 8'h00 && restart_addr_ff == 8'h00)
		else $error("restart not at page zero address zero");
	a_pin_force: assert property (port_latch_force_one_ff == sys_reset_ff && port_open_drain_ff == sys_reset_ff && seg_pullup_off_ff == sys_reset_ff)
		else $error("port forcing differs from reset state");
	// internal state clears one cycle after reset rises, outputs one more
	a_reset_state: assert property ($rose(sys_reset_ff) |-> ##2 !armed_ff && mode_ff == 2'b00 && !power_down_flag_ff)
		else $error("state not cleared on reset");
	a_unarmed_nop: assert property ((exec_enter_clock_run_sleep || exec_enter_ram_retention) && cpu_run_ff && !armed_ff && !$past(exec_arm_power_down) |-> ##2 mode_ff == 2'b00)
		else $error("unarmed power-off left run mode");
	a_clk_entry: assert property (armed_ff && cpu_run_ff && exec_enter_clock_run_sleep |-> ##2 mode_ff == 2'b01 && !armed_ff && !cpu_run_ff)
		else $error("clock-run entry wrong");
	a_ram_entry: assert property (armed_ff && cpu_run_ff && exec_enter_ram_retention && !exec_enter_clock_run_sleep |-> ##2 mode_ff == 2'b10 && !armed_ff)
		else $error("retention entry wrong");
	// reset overrides the enables before the shown mode returns to run
	a_mode_funcs: assert property (mode_ff != 2'b00 && !sys_reset_ff |-> !main_osc_en_ff && ram_retain_ff && sub_osc_en_ff == (mode_ff == 2'b01) && lcd_en_ff == (mode_ff == 2'b01) && slow_timer_en_ff == (mode_ff == 2'b01))
		else $error("function enables wrong for mode");
	a_timer_wake: assert property ($rose(slow_timer_expiry_flag) && mode_ff == 2'b01 |-> ##2 restart_strobe_ff && mode_ff == 2'b00 ##[0:1] power_down_flag_ff)
		else $error("timer expiry gave no warm start");
	a_ret_no_timer: assert property (mode_ff == 2'b10 && slow_timer_expiry_flag && wake_quiet_ff == 3'h7 |-> ##2 !restart_strobe_ff)
		else $error("timer expiry woke retention");
	a_latch_set: assert property (exec_latch_dropout_detect_enable && cpu_run_ff && !sys_reset_ff |-> ##2 dropout_latched_ff)
		else $error("detector latch not set");
	a_latch_keep: assert property (dropout_latched_ff && !sys_reset_ff |=> dropout_latched_ff || sys_reset_ff)
		else $error("detector latch cleared without reset");
endmodule

`default_nettype wire

// ==== rpd_seq_tb.sv ====
/*
 * Bench for the sequencer: drives reset sources, wakeups and instructions
 * and checks the outputs. Assumes design, core model and monitor compiled.
 */
`timescale 1ns/1ps
`default_nettype none

module rpd_seq_tb;
	// -------------------------------------------------------------
	// signals, named as the ports
	// -------------------------------------------------------------
	logic core_clk, rst, reset_pin_n, dropout_threshold, wakeup_ext;
	logic watchdog_reset, slow_timer_expiry_flag;
	logic [2:0] op_code;
	logic exec_arm_power_down, exec_enter_clock_run_sleep;
	logic exec_enter_ram_retention, exec_latch_dropout_detect_enable;
	logic sys_reset_ff, restart_strobe_ff, power_down_flag_ff, cpu_run_ff, armed_ff;
	logic [7:0] restart_page_ff, restart_addr_ff;
	logic [1:0] mode_ff;
	logic port_latch_force_one_ff, port_open_drain_ff, seg_pullup_off_ff;
	logic main_osc_en_ff, sub_osc_en_ff, lcd_en_ff, slow_timer_en_ff;
	logic ram_retain_ff, dropout_detect_active_ff, dropout_latched_ff;
	int fail_count = 0;
	int checked = 0;

	// short power-on stretch keeps the run brief
	rpd_seq #(.POR_CYCLES(8), .HOLD_CYCLES(4)) dut_u (.*);
	rpd_core_model core_u (.*);

	// 25 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// one instruction, then two idle cycles
	task issue(input logic [2:0] code);
		op_code = code;
		tick(1);
		op_code = 3'h0;
		tick(2);
	endtask

	// bounded wait for the restart strobe, then one cycle
	task wait_start();
		int n;
		n = 0;
		while (restart_strobe_ff !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		check(restart_strobe_ff, 8'h01);
		tick(1);
	endtask

	task report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// -------------------------------------------------------------
	// tests
	// -------------------------------------------------------------
	initial begin
		rst = 1'b1;
		reset_pin_n = 1'b1;
		dropout_threshold = 1'b0;
		wakeup_ext = 1'b0;
		watchdog_reset = 1'b0;
		slow_timer_expiry_flag = 1'b0;
		op_code = 3'h0;
		tick(8);
		check(sys_reset_ff, 8'h01);
		check({port_latch_force_one_ff, port_open_drain_ff, seg_pullup_off_ff}, 8'h07);
		rst = 1'b0;
		wait_start();
		check({armed_ff, mode_ff, power_down_flag_ff, dropout_latched_ff, cpu_run_ff}, 8'h01);
		// power-off without arm
		issue(3'h2);
		issue(3'h3);
		check({mode_ff, cpu_run_ff}, 8'h01);
		// clock-run sleep, timer wake
		issue(3'h1);
		issue(3'h2);
		check({mode_ff, armed_ff, main_osc_en_ff, sub_osc_en_ff, lcd_en_ff, slow_timer_en_ff}, 8'h27);
		slow_timer_expiry_flag = 1'b1;
		tick(1);
		slow_timer_expiry_flag = 1'b0;
		wait_start();
		check({mode_ff, power_down_flag_ff, cpu_run_ff}, 8'h03);
		// retention: timer ignored, pin wakes
		issue(3'h1);
		issue(3'h3);
		check({mode_ff, sub_osc_en_ff, lcd_en_ff, ram_retain_ff}, 8'h11);
		slow_timer_expiry_flag = 1'b1;
		tick(1);
		slow_timer_expiry_flag = 1'b0;
		tick(6);
		check(mode_ff, 8'h02);
		wakeup_ext = 1'b1;
		wait_start();
		wakeup_ext = 1'b0;
		check({mode_ff, power_down_flag_ff}, 8'h01);
		// unlatched dropout ignored in retention
		issue(3'h1);
		issue(3'h3);
		dropout_threshold = 1'b1;
		tick(10);
		check({sys_reset_ff, mode_ff}, 8'h02);
		check(dropout_detect_active_ff, 8'h00);
		dropout_threshold = 1'b0;
		tick(6);
		wakeup_ext = 1'b1;
		wait_start();
		wakeup_ext = 1'b0;
		// latch detector twice, dropout in clock-run
		issue(3'h4);
		issue(3'h4);
		check(dropout_latched_ff, 8'h01);
		issue(3'h1);
		issue(3'h2);
		check(dropout_detect_active_ff, 8'h01);
		dropout_threshold = 1'b1;
		tick(8);
		check({sys_reset_ff, mode_ff, armed_ff}, 8'h08);
		dropout_threshold = 1'b0;
		wait_start();
		check({power_down_flag_ff, dropout_latched_ff}, 8'h00);
		// pin reset clears arm
		issue(3'h1);
		reset_pin_n = 1'b0;
		// sync latency, then arm clears a cycle after reset and shows one later
		tick(7);
		check({sys_reset_ff, armed_ff}, 8'h02);
		reset_pin_n = 1'b1;
		wait_start();
		check(cpu_run_ff, 8'h01);
		// watchdog reset
		watchdog_reset = 1'b1;
		tick(1);
		watchdog_reset = 1'b0;
		tick(1);
		check({sys_reset_ff, power_down_flag_ff}, 8'h02);
		wait_start();
		report_and_stop();
	end

	// watchdog: tests need well under 1000 cycles
	initial begin
		#100000;
		fail_count++;
		report_and_stop();
	end
endmodule

bind rpd_seq rpd_seq_monitor mon_u (.*);

`default_nettype wire

// ==== rpd_sync3.sv ====
/*
 * Three-stage pin synchroniser; the output follows once stages two and
 * three agree. Assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rpd_sync3 #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// pin and filtered level
	input wire logic async_in,
	output logic level_ff
);
	logic s1_ff; // first stage, read only by s2
	logic s2_ff; // second stage
	logic s3_ff; // third stage
	logic agree; // stages two and three match

	assign agree = (s2_ff == s3_ff);

	// shift chain and qualified level
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			level_ff <= RST_VAL;
		end else begin
			s1_ff <= async_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (agree) begin
				level_ff <= s3_ff;
			end
		end
	end
endmodule

`default_nettype wire
